// ==== hw/eia_pkg.sv ====
// Package of constants and types for the extended integer arithmetic unit
package eia_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the APB slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_REG_R = 8'h04;
  localparam logic [7:0] OFS_PAIRED = 8'h08;
  localparam logic [7:0] OFS_SRC = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RES_R = 8'h18;
  localparam logic [7:0] OFS_RES_PAIRED = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 9;
  localparam int REG_HI = 8;
  localparam int REG_LO = 6;
  localparam int SRC_HI = 5;
  localparam int SRC_LO = 0;
  localparam int CTRL_START_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_C_BIT = 2;
  localparam int ST_V_BIT = 3;
  localparam int ST_Z_BIT = 4;
  localparam int ST_N_BIT = 5;
  localparam int ST_WR_R_BIT = 6;
  localparam int ST_WR_P_BIT = 7;
  localparam int ST_ILLEGAL_BIT = 8;

  // ----------------------------------------------------------------
  // Opcodes (octal prefixes of the instruction word)
  // ----------------------------------------------------------------
  localparam logic [6:0] OPC_MUL = 7'h38;
  localparam logic [6:0] OPC_DIV = 7'h39;
  localparam logic [6:0] OPC_SHIFT = 7'h3a;
  localparam logic [6:0] OPC_PAIR_SHIFT = 7'h3b;

  // ----------------------------------------------------------------
  // Reset values and iteration counts
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [31:0] RESET_DWORD = 32'h0000_0000;
  localparam logic [5:0] DIV_STEPS = 6'h20;
  localparam logic [14:0] QUOT_PAD = 15'h0000;

  typedef enum logic [1:0] {
    EIA_OP_MUL,
    EIA_OP_DIV,
    EIA_OP_SHIFT,
    EIA_OP_PAIR
  } eia_op_t;

  typedef enum logic [1:0] {
    EIA_IDLE,
    EIA_RUN,
    EIA_FIN
  } eia_state_t;

endpackage : eia_pkg

// ==== hw/eia_unit.sv ====
// Extended integer arithmetic unit: multiply, divide and arithmetic shifts behind APB
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module eia_unit (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic busy_o,
  output logic done_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    eia_pkg::eia_state_t st;
    eia_pkg::eia_op_t op;
    logic [2:0] rnum;
    logic [31:0] acc;
    logic [5:0] cnt;
    logic left;
    logic [16:0] rem;
    logic [15:0] dvs;
    logic dd_neg;
    logic dv_neg;
    logic [15:0] instr;
    logic [15:0] r_val;
    logic [15:0] p_val;
    logic [15:0] src_val;
    logic [15:0] res_r;
    logic [15:0] res_p;
    logic nf;
    logic zf;
    logic vf;
    logic cf;
    logic wr_r;
    logic wr_p;
    logic done;
    logic illegal;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic busy;
    logic done_pulse;
  } eia_state_s_t;

  eia_state_s_t s_reg;
  eia_state_s_t s_next;

  logic setup_phase;
  logic wr_access;
  logic [6:0] opc;
  logic signed [31:0] product;
  logic [31:0] dd_word;
  logic [31:0] dd_mag;
  logic [15:0] dv_mag;
  logic [16:0] rem_try;
  logic [15:0] quot;
  logic [15:0] rmdr;
  logic msb_old;
  logic msb_new;
  logic [31:0] stepped;
  logic [5:0] cnt_raw;

  assign setup_phase = psel_i && !penable_i;
  assign wr_access = psel_i && penable_i && pwrite_i && s_reg.pready;
  assign opc = s_reg.instr[eia_pkg::OPC_HI:eia_pkg::OPC_LO];
  assign product = $signed(s_reg.r_val) * $signed(s_reg.src_val);
  assign dd_word = {s_reg.r_val, s_reg.p_val};
  assign dd_mag = dd_word[31] ? (~dd_word + 32'h0000_0001) : dd_word;
  assign dv_mag = s_reg.src_val[15] ? (~s_reg.src_val + 16'h0001) : s_reg.src_val;
  assign rem_try = {s_reg.rem[15:0], s_reg.acc[31]};
  assign quot = (s_reg.dd_neg ^ s_reg.dv_neg) ? (~s_reg.acc[15:0] + 16'h0001) : s_reg.acc[15:0];
  assign rmdr = s_reg.dd_neg ? (~s_reg.rem[15:0] + 16'h0001) : s_reg.rem[15:0];
  assign cnt_raw = s_reg.src_val[eia_pkg::SRC_HI:eia_pkg::SRC_LO];

  // ----------------------------------------------------------------
  // One arithmetic shift step
  // ----------------------------------------------------------------
  always_comb begin
    msb_old = (s_reg.op == eia_pkg::EIA_OP_PAIR) ? s_reg.acc[31] : s_reg.acc[15];
    if (s_reg.op == eia_pkg::EIA_OP_PAIR) begin
      // Right shift of {R,R} brings R's low bits in on top: a rotate for odd R
      stepped = s_reg.left ? {s_reg.acc[30:0], 1'b0} : {s_reg.acc[31], s_reg.acc[31:1]};
      msb_new = stepped[31];
    end else begin
      stepped = s_reg.left ? {16'h0000, s_reg.acc[14:0], 1'b0} : {16'h0000, s_reg.acc[15], s_reg.acc[15:1]};
      msb_new = stepped[15];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // APB: zero wait states, answer flopped in the first access cycle
    s_next.pready = setup_phase;
    s_next.pslverr = 1'b0;
    if (setup_phase) begin
      s_next.prdata = eia_pkg::RESET_DWORD;
      unique case (paddr_i)
        eia_pkg::OFS_INSTR: s_next.prdata = {16'h0000, s_reg.instr};
        eia_pkg::OFS_REG_R: s_next.prdata = {16'h0000, s_reg.r_val};
        eia_pkg::OFS_PAIRED: s_next.prdata = {16'h0000, s_reg.p_val};
        eia_pkg::OFS_SRC: s_next.prdata = {16'h0000, s_reg.src_val};
        eia_pkg::OFS_CTRL: s_next.prdata = eia_pkg::RESET_DWORD;
        eia_pkg::OFS_STATUS: begin
          s_next.prdata[eia_pkg::ST_BUSY_BIT] = s_reg.st != eia_pkg::EIA_IDLE;
          s_next.prdata[eia_pkg::ST_DONE_BIT] = s_reg.done;
          s_next.prdata[eia_pkg::ST_C_BIT] = s_reg.cf;
          s_next.prdata[eia_pkg::ST_V_BIT] = s_reg.vf;
          s_next.prdata[eia_pkg::ST_Z_BIT] = s_reg.zf;
          s_next.prdata[eia_pkg::ST_N_BIT] = s_reg.nf;
          s_next.prdata[eia_pkg::ST_WR_R_BIT] = s_reg.wr_r;
          s_next.prdata[eia_pkg::ST_WR_P_BIT] = s_reg.wr_p;
          s_next.prdata[eia_pkg::ST_ILLEGAL_BIT] = s_reg.illegal;
        end
        eia_pkg::OFS_RES_R: s_next.prdata = {16'h0000, s_reg.res_r};
        eia_pkg::OFS_RES_PAIRED: s_next.prdata = {16'h0000, s_reg.res_p};
        default: s_next.pslverr = 1'b1;
      endcase
      // Operands are frozen while an instruction runs, so the result stays consistent
      if (pwrite_i && s_reg.st != eia_pkg::EIA_IDLE && paddr_i != eia_pkg::OFS_STATUS
          && paddr_i != eia_pkg::OFS_RES_R && paddr_i != eia_pkg::OFS_RES_PAIRED) begin
        s_next.pslverr = 1'b1;
      end
    end

    if (wr_access && !s_reg.pslverr && s_reg.st == eia_pkg::EIA_IDLE) begin
      unique case (paddr_i)
        eia_pkg::OFS_INSTR: s_next.instr = pwdata_i[15:0];
        eia_pkg::OFS_REG_R: s_next.r_val = pwdata_i[15:0];
        eia_pkg::OFS_PAIRED: s_next.p_val = pwdata_i[15:0];
        eia_pkg::OFS_SRC: s_next.src_val = pwdata_i[15:0];
        default: s_next.p_val = s_reg.p_val;
      endcase
    end

    unique case (s_reg.st)
      eia_pkg::EIA_IDLE: begin
        if (wr_access && paddr_i == eia_pkg::OFS_CTRL && pwdata_i[eia_pkg::CTRL_START_BIT]) begin
          s_next.done = 1'b0;
          s_next.illegal = 1'b0;
          s_next.wr_r = 1'b0;
          s_next.wr_p = 1'b0;
          s_next.rnum = s_reg.instr[eia_pkg::REG_HI:eia_pkg::REG_LO];
          s_next.st = eia_pkg::EIA_RUN;
          s_next.rem = 17'h00000;
          s_next.dvs = dv_mag;
          s_next.dd_neg = dd_word[31];
          s_next.dv_neg = s_reg.src_val[15];
          s_next.cf = 1'b0;
          s_next.vf = 1'b0;
          // Count: signed six bits, magnitude taken for the step loop
          s_next.left = !cnt_raw[5];
          s_next.cnt = cnt_raw[5] ? (~cnt_raw + 6'h01) : cnt_raw;
          unique case (opc)
            eia_pkg::OPC_MUL: begin
              s_next.op = eia_pkg::EIA_OP_MUL;
            end
            eia_pkg::OPC_DIV: begin
              s_next.op = eia_pkg::EIA_OP_DIV;
              s_next.acc = dd_mag;
              s_next.cnt = eia_pkg::DIV_STEPS;
            end
            eia_pkg::OPC_SHIFT: begin
              s_next.op = eia_pkg::EIA_OP_SHIFT;
              s_next.acc = {16'h0000, s_reg.r_val};
            end
            eia_pkg::OPC_PAIR_SHIFT: begin
              s_next.op = eia_pkg::EIA_OP_PAIR;
              // Odd register: both halves are the same word
              s_next.acc = {s_reg.r_val, s_reg.instr[eia_pkg::REG_LO] ? s_reg.r_val : s_reg.p_val};
            end
            default: begin
              s_next.illegal = 1'b1;
              s_next.st = eia_pkg::EIA_FIN;
            end
          endcase
        end
      end

      eia_pkg::EIA_RUN: begin
        unique case (s_reg.op)
          eia_pkg::EIA_OP_MUL: begin
            s_next.nf = product[31];
            s_next.zf = product == 32'sh0000_0000;
            s_next.vf = 1'b0;
            s_next.cf = product[31:15] != {17{product[15]}};
            s_next.wr_r = 1'b1;
            if (s_reg.rnum[0]) begin
              s_next.res_r = product[15:0];
            end else begin
              s_next.res_r = product[31:16];
              s_next.res_p = product[15:0];
              s_next.wr_p = 1'b1;
            end
            s_next.st = eia_pkg::EIA_FIN;
          end
          eia_pkg::EIA_OP_DIV: begin
            if (s_reg.dvs == 16'h0000) begin
              s_next.vf = 1'b1;
              s_next.cf = 1'b1;
              s_next.nf = 1'b0;
              s_next.zf = 1'b0;
              s_next.st = eia_pkg::EIA_FIN;
            end else if (s_reg.cnt == eia_pkg::DIV_STEPS && s_reg.acc >= {1'b0, s_reg.dvs, eia_pkg::QUOT_PAD}) begin
              // Quotient magnitude would need more than 15 bits: abort, no write-back
              s_next.vf = 1'b1;
              s_next.cf = 1'b0;
              s_next.nf = 1'b0;
              s_next.zf = 1'b0;
              s_next.st = eia_pkg::EIA_FIN;
            end else if (s_reg.cnt != 6'h00) begin
              // Restoring division on magnitudes, one quotient bit per cycle
              s_next.cnt = s_reg.cnt - 6'h01;
              if (rem_try >= {1'b0, s_reg.dvs}) begin
                s_next.rem = rem_try - {1'b0, s_reg.dvs};
                s_next.acc = {s_reg.acc[30:0], 1'b1};
              end else begin
                s_next.rem = rem_try;
                s_next.acc = {s_reg.acc[30:0], 1'b0};
              end
            end else begin
              s_next.res_r = quot;
              s_next.res_p = rmdr;
              s_next.nf = quot[15];
              s_next.zf = quot == 16'h0000;
              s_next.vf = 1'b0;
              s_next.cf = 1'b0;
              // Paired register is rnum+1; an odd rnum is left to software
              s_next.wr_r = 1'b1;
              s_next.wr_p = 1'b1;
              s_next.st = eia_pkg::EIA_FIN;
            end
          end
          default: begin
            if (s_reg.cnt != 6'h00) begin
              s_next.cnt = s_reg.cnt - 6'h01;
              s_next.acc = stepped;
              s_next.cf = s_reg.left ? msb_old : s_reg.acc[0];
              if (msb_new != msb_old) begin
                s_next.vf = 1'b1;
              end
            end else begin
              s_next.wr_r = 1'b1;
              if (s_reg.op == eia_pkg::EIA_OP_PAIR) begin
                s_next.nf = s_reg.acc[31];
                s_next.zf = s_reg.acc == 32'h0000_0000;
                s_next.res_r = s_reg.rnum[0] ? s_reg.acc[15:0] : s_reg.acc[31:16];
                s_next.res_p = s_reg.acc[15:0];
                s_next.wr_p = !s_reg.rnum[0];
              end else begin
                s_next.nf = s_reg.acc[15];
                s_next.zf = s_reg.acc[15:0] == 16'h0000;
                s_next.res_r = s_reg.acc[15:0];
              end
              s_next.st = eia_pkg::EIA_FIN;
            end
          end
        endcase
      end

      eia_pkg::EIA_FIN: begin
        s_next.done = 1'b1;
        s_next.st = eia_pkg::EIA_IDLE;
      end
      default: begin
        s_next.st = eia_pkg::EIA_IDLE;
      end
    endcase
    // Busy covers the finish cycle too, so a pending interrupt waits for the write-back
    s_next.busy = s_next.st != eia_pkg::EIA_IDLE;
    s_next.done_pulse = s_next.st == eia_pkg::EIA_FIN;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.st <= eia_pkg::EIA_IDLE;
      s_reg.instr <= eia_pkg::RESET_WORD;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata_o = s_reg.prdata;
  assign pready_o = s_reg.pready;
  assign pslverr_o = s_reg.pslverr;
  assign busy_o = s_reg.busy;
  assign done_o = s_reg.done_pulse;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic fin;
  assign fin = s_reg.st == eia_pkg::EIA_FIN;

  a_busy_defers_irq: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (s_reg.st != eia_pkg::EIA_IDLE) |-> busy_o)
    else $error("busy dropped while an instruction runs");

  a_apb_ready_time: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (psel_i && !penable_i) |=> pready_o)
    else $error("pready not given in first access cycle");

  a_mul_even_product: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (fin && s_reg.op == eia_pkg::EIA_OP_MUL && !s_reg.rnum[0] && !s_reg.illegal)
      |-> ({s_reg.res_r, s_reg.res_p} == 32'(product)) && s_reg.wr_p)
    else $error("multiply product halves wrong");

  a_mul_carry_flag: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (fin && s_reg.op == eia_pkg::EIA_OP_MUL && !s_reg.illegal)
      |-> (s_reg.cf == ((product > 32'sd32767) || (product < -32'sd32768))) && !s_reg.vf)
    else $error("multiply C or V wrong");

  a_div_zero_flags: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (fin && s_reg.op == eia_pkg::EIA_OP_DIV && !s_reg.illegal)
      |-> (s_reg.cf == (s_reg.src_val == 16'h0000)))
    else $error("divide C flag wrong");

  a_div_abort_nowrite: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (fin && s_reg.op == eia_pkg::EIA_OP_DIV && s_reg.vf) |-> !s_reg.wr_r && !s_reg.wr_p)
    else $error("aborted divide wrote a result");

  a_div_rem_sign: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (fin && s_reg.op == eia_pkg::EIA_OP_DIV && s_reg.wr_p && s_reg.res_p != 16'h0000)
      |-> s_reg.res_p[15] == s_reg.r_val[15])
    else $error("remainder sign differs from dividend");

  a_div_quot_flags: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (fin && s_reg.op == eia_pkg::EIA_OP_DIV && s_reg.wr_r)
      |-> (s_reg.nf == s_reg.res_r[15]) && (s_reg.zf == (s_reg.res_r == 16'h0000)))
    else $error("divide N or Z wrong");

  a_shift_nz_flags: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (fin && s_reg.op == eia_pkg::EIA_OP_SHIFT && !s_reg.illegal)
      |-> (s_reg.nf == s_reg.res_r[15]) && (s_reg.zf == (s_reg.res_r == 16'h0000)))
    else $error("shift N or Z wrong");

  a_shift_done_pulse: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ($rose(busy_o) && s_reg.op != eia_pkg::EIA_OP_DIV && s_reg.op != eia_pkg::EIA_OP_MUL
      && s_reg.cnt == 6'h01 && s_reg.st == eia_pkg::EIA_RUN) |-> ##2 done_o)
    else $error("one-place shift did not finish in time");

endmodule : eia_unit

`default_nettype wire

// ==== tb/eia_cpu_model.sv ====
// Processor-side APB master model that loads operands and starts instructions
`timescale 1ns/1ps
`default_nettype none

module eia_cpu_model (
  input wire logic ref_clk_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o
);
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'hff;
    pwdata_o = 32'hffff_ffff;
  end

  // Starts one edge after the call so back-to-back calls never drive psel twice in a step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= wd;
    @(posedge ref_clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 50);
    rd = prdata_i;
    err = pslverr_i;
    ok = (pready_i === 1'b1);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // A released bus must not keep looking valid
    pwrite_o <= ~wr;
    paddr_o <= ~a;
    pwdata_o <= ~wd;
  endtask : xfer
endmodule : eia_cpu_model

`default_nettype wire

// ==== tb/eia_unit_tb_top.sv ====
// Self-checking testbench for the extended integer arithmetic unit
`timescale 1ns/1ps
`default_nettype none

module eia_unit_tb_top;
  logic ref_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, busy, done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int errors = 0;
  int n_checks = 0;

  eia_unit dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .busy_o(busy), .done_o(done));
  eia_cpu_model cpu (.ref_clk_i(ref_clk_i), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ------------------------------------------------------------
  // Reporting and bus helpers
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    logic ok;
    cpu.xfer(wr, a, wd, rd, err, ok);
    if (!ok) begin
      errors++;
      complete_run();
    end
  endtask : bus

  // ------------------------------------------------------------
  // Expected results: {write paired, write r, n, z, v, c, result r, result paired}
  // ------------------------------------------------------------
  function automatic logic [37:0] expect_of(input logic [1:0] op, input logic odd,
      input logic [15:0] r, input logic [15:0] rv, input logic [15:0] s);
    logic [31:0] w;
    logic n, z, v, c, wp, wr;
    longint dd, ds;
    int k;
    int lo;
    v = 1'b0;
    c = 1'b0;
    wr = 1'b1;
    wp = ~odd & (op != 2'd2);
    dd = longint'($signed({r, rv}));
    ds = longint'($signed(s));
    k = int'($signed(s[5:0]));
    lo = (op == 2'd2) ? 16 : 0;
    w = (op == 2'd2) ? {r, 16'h0} : (odd ? {r, r} : {r, rv});
    if (op == 2'd0) begin
      dd = longint'($signed(r)) * ds;
      w = dd[31:0];
      c = (dd > 32767) || (dd < -32768);
    end else if (op == 2'd1) begin
      wp = 1'b1;
      if (ds == 0 || (dd < 0 ? -dd : dd) >= (ds < 0 ? -ds : ds) * 32768) begin
        v = 1'b1;
        c = (ds == 0);
        wr = 1'b0;
        wp = 1'b0;
      end else begin
        w = {16'(dd / ds), 16'(dd % ds)};
      end
    end else begin
      for (int i = 0; i < k; i++) begin
        c = w[31];
        w = w << 1;
        v = v | (w[31] ^ c);
      end
      for (int i = 0; i < -k; i++) begin
        c = w[lo];
        w = 32'($signed(w) >>> 1);
      end
    end
    n = wr & w[31];
    z = wr & ((op == 2'd1 || op == 2'd2) ? (w[31:16] == 16'h0) : (w == 32'h0));
    if (odd && (op == 2'd0 || op == 2'd3)) begin
      w = {w[15:0], w[15:0]};
    end
    return {wp, wr, n, z, v, c, w};
  endfunction : expect_of

  task automatic run(input logic [6:0] opc, input logic [2:0] rn, input logic [15:0] r,
      input logic [15:0] rv, input logic [15:0] s);
    logic [37:0] e;
    logic [31:0] rd;
    logic err;
    logic seen;
    logic legal;
    int n;
    e = expect_of(opc[1:0], rn[0], r, rv, s);
    legal = (opc[6:2] == 5'h0e);
    seen = 1'b0;
    n = 0;
    bus(1'b1, eia_pkg::OFS_INSTR, {16'h0, opc, rn, s[5:0]}, rd, err);
    bus(1'b1, eia_pkg::OFS_REG_R, {16'h0, r}, rd, err);
    bus(1'b1, eia_pkg::OFS_PAIRED, {16'h0, rv}, rd, err);
    bus(1'b1, eia_pkg::OFS_SRC, {16'h0, s}, rd, err);
    bus(1'b1, eia_pkg::OFS_CTRL, 32'h1, rd, err);
    if (opc == eia_pkg::OPC_DIV && e[36]) begin
      // Operand change in mid-divide must be refused and leave the result intact
      bus(1'b1, eia_pkg::OFS_SRC, 32'h0, rd, err);
      check({31'h0, err}, 32'h1);
    end
    while (done !== 1'b1 && n < 200) begin
      @(posedge ref_clk_i);
      seen = seen | (busy === 1'b1);
      n++;
    end
    if (n >= 200) begin
      errors++;
      complete_run();
    end
    // Busy spans the finish cycle with done; one edge later both have dropped
    @(posedge ref_clk_i);
    check({29'h0, seen | ~legal, busy, done}, 32'h4);
    bus(1'b0, eia_pkg::OFS_STATUS, 32'h0, rd, err);
    if (!legal) begin
      check({30'h0, rd[8], rd[1]}, 32'h3);
    end else begin
      check({23'h0, rd[8:0]}, {23'h0, 1'b0, e[37:32], 2'b10});
      if (e[36]) begin
        bus(1'b0, eia_pkg::OFS_RES_R, 32'h0, rd, err);
        check(rd, {16'h0, e[31:16]});
      end
      if (e[37]) begin
        bus(1'b0, eia_pkg::OFS_RES_PAIRED, 32'h0, rd, err);
        check(rd, {16'h0, e[15:0]});
      end
    end
  endtask : run

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic err;
    logic [1:0] k;
    logic [15:0] a;
    rst_i = 1'b1;
    void'($urandom(8239));
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    bus(1'b0, eia_pkg::OFS_STATUS, 32'h0, rd, err);
    check(rd, 32'h0);
    bus(1'b0, 8'h20, 32'h0, rd, err);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    run(eia_pkg::OPC_MUL, 3'd0, 16'h7fff, 16'h0, 16'h7fff);
    run(eia_pkg::OPC_MUL, 3'd2, 16'hffff, 16'h0, 16'h8000);
    run(eia_pkg::OPC_MUL, 3'd1, 16'h0100, 16'h0, 16'h0008);
    run(eia_pkg::OPC_MUL, 3'd3, 16'hff00, 16'h0, 16'h0100);
    run(eia_pkg::OPC_DIV, 3'd0, 16'h0000, 16'h2001, 16'h0002);
    run(eia_pkg::OPC_DIV, 3'd2, 16'hffff, 16'hfff9, 16'h0002);
    run(eia_pkg::OPC_DIV, 3'd4, 16'h1234, 16'h5678, 16'h0000);
    run(eia_pkg::OPC_DIV, 3'd6, 16'h0001, 16'h0000, 16'h0002);
    run(eia_pkg::OPC_DIV, 3'd0, 16'h0000, 16'h7ffe, 16'hffff);
    run(eia_pkg::OPC_SHIFT, 3'd3, 16'h029c, 16'h0, 16'h0003);
    run(eia_pkg::OPC_SHIFT, 3'd1, 16'h4001, 16'h0, 16'hff9f);
    run(eia_pkg::OPC_SHIFT, 3'd5, 16'h8001, 16'h0, 16'h0020);
    run(eia_pkg::OPC_SHIFT, 3'd0, 16'h1234, 16'h0, 16'h0000);
    run(eia_pkg::OPC_PAIR_SHIFT, 3'd2, 16'h8000, 16'h0001, 16'h003f);
    run(eia_pkg::OPC_PAIR_SHIFT, 3'd0, 16'h0000, 16'h0001, 16'h001f);
    run(eia_pkg::OPC_PAIR_SHIFT, 3'd5, 16'h1234, 16'hdead, 16'h0030);
    run(7'h00, 3'd0, 16'h0001, 16'h0002, 16'h0003);
    // Reset in mid-divide must drop busy and clear every status bit
    bus(1'b1, eia_pkg::OFS_INSTR, {16'h0, eia_pkg::OPC_DIV, 9'h002}, rd, err);
    bus(1'b1, eia_pkg::OFS_CTRL, 32'h1, rd, err);
    repeat (4) @(posedge ref_clk_i);
    check({31'h0, busy}, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    check({30'h0, busy, done}, 32'h0);
    bus(1'b0, eia_pkg::OFS_STATUS, 32'h0, rd, err);
    check(rd, 32'h0);
    repeat (40) begin
      k = 2'($urandom);
      a = 16'($urandom);
      // Divide keeps an even register and a narrowed dividend so most quotients fit
      run({5'h0e, k}, 3'($urandom) & ((k == 2'd1) ? 3'h6 : 3'h7),
        (k == 2'd1) ? 16'($signed(a) >>> 9) : a, 16'($urandom), 16'($urandom));
    end
    complete_run();
  end
endmodule : eia_unit_tb_top

`default_nettype wire
